//--- hdl/asf_pkg.sv
package asf_pkg;

    // ****************************************************************
    // Word layout and frame edge counts
    // ****************************************************************
    localparam int unsigned RES_W      = 12;
    localparam int unsigned LEAD_ZEROS = 3;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned CNT_W      = 5;

    localparam logic [CNT_W-1:0] FALLS_SHUT_MIN   = 5'h02;
    localparam logic [CNT_W-1:0] FALLS_NORMAL_MIN = 5'h0a;
    localparam logic [CNT_W-1:0] FALLS_FRAME      = 5'h10;
    localparam logic [CNT_W-1:0] RISES_TRACK      = 5'h0d;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned MCLK_KHZ      = 40000;
    localparam int unsigned SCLK_HALF_DEF = 4;
    // Quiet time has no printed figure here; plain default
    localparam int unsigned QUIET_NS      = 100;
    localparam int unsigned QUIET_CYC_RAW = (QUIET_NS * MCLK_KHZ + 999999) / 1000000;
    localparam int unsigned QUIET_CYC     = (QUIET_CYC_RAW < 1) ? 1 : QUIET_CYC_RAW;

    // ****************************************************************
    // Modes and states
    // ****************************************************************
    typedef enum logic {
        MODE_NORMAL,
        MODE_SHUTDOWN
    } asf_mode_t;

    // Supply-up mode is undefined; shutdown is the safe pick
    localparam asf_mode_t RST_MODE = MODE_SHUTDOWN;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_LEAD,
        HS_LOW,
        HS_HIGH,
        HS_QUIET
    } asf_hst_state_t;

endpackage

//--- hdl/asf_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface asf_link_if;
    logic csN;
    logic sclk;
    logic sdo;
    logic sdoOe;
    logic sdoLine;

    // Weak pull-up stands in for the released line
    assign sdoLine = sdoOe ? sdo : 1'b1;

    modport dev (
        input  csN,
        input  sclk,
        output sdo,
        output sdoOe
    );

    modport host (
        output csN,
        output sclk,
        input  sdoLine
    );
endinterface

`default_nettype wire

//--- hdl/asf_device.sv
// Behaviour
// - Select fall: normal mode, new frame
// - Rise at falls 2..9: abort, release, shutdown
// - Rise before fall 2: mode unchanged
// - Rise at falls 10..15: abort, stay normal
// - Host holds select past fall 10
// - Host gives sixteen clocks per word
// - Idle-low select must rise before next
// - Release after sixteen; host waits quiet
// - Shutdown lasts until select falls
// - Shutdown switches analog circuitry off
// - Wake conversion unusable, second valid
// - Wake frame rise before 10: shutdown
// - Powered up after sixteen wake clocks
// - Host does one dummy after supply
// - Quiet time also after dummy
// - Twenty-clock frames for top throughput
// - Power trade: rise between 10, 15
// - Three zeros, twelve bits, MSB first
// - Shift on fall, capture on rise; host samples as it drives the fall
// - Select fall drives output, holds sample
// - Back to track on rise 13
`timescale 1ns/100ps
`default_nettype none

module asf_device
    import asf_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    asf_link_if.dev               link,
    input  wire logic [RES_W-1:0] sampleIn,
    output logic                  shutdownMode,
    output logic                  analogOn,
    output logic                  tracking,
    output logic                  poweredUp,
    output logic                  convDone,
    output logic                  convValid,
    output logic                  frameAbort
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0]        sclkSync;
        logic [2:0]        csSync;
        logic              sclkLvl;
        logic              csLvl;
        asf_mode_t         mode;
        asf_mode_t         frameMode;
        logic              inFrame;
        logic              wake;
        logic              powered;
        logic [CNT_W-1:0]  falls;
        logic [CNT_W-1:0]  rises;
        logic [WORD_W-1:0] shifter;
        logic              sdo;
        logic              sdoOe;
        logic              holding;
        logic              done;
        logic              valid;
        logic              abort;
        logic              shutOut;
        logic              analogOut;
        logic              trackOut;
    } asf_dev_st_t;

    asf_dev_st_t st;
    asf_dev_st_t next_st;

    logic sclkFall;
    logic sclkRise;
    logic csFall;
    logic csRise;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st       = st;
        next_st.done  = 1'b0;
        next_st.valid = 1'b0;
        next_st.abort = 1'b0;

        // Bit 0 feeds only bit 1; a level counts once bits 1 and 2 agree
        next_st.sclkSync = {st.sclkSync[1:0], link.sclk};
        next_st.csSync   = {st.csSync[1:0], link.csN};
        if (st.sclkSync[1] == st.sclkSync[2]) begin
            next_st.sclkLvl = st.sclkSync[2];
        end
        if (st.csSync[1] == st.csSync[2]) begin
            next_st.csLvl = st.csSync[2];
        end

        sclkFall = st.sclkLvl & ~next_st.sclkLvl;
        sclkRise = ~st.sclkLvl & next_st.sclkLvl;
        csFall   = st.csLvl & ~next_st.csLvl;
        csRise   = ~st.csLvl & next_st.csLvl;

        if (csFall) begin
            // Only a fall starts a frame, so an idle-low select must rise first
            next_st.mode      = MODE_NORMAL;
            next_st.frameMode = st.mode;
            next_st.inFrame   = 1'b1;
            next_st.wake      = (st.mode == MODE_SHUTDOWN);
            if (st.mode == MODE_SHUTDOWN) begin
                next_st.powered = 1'b0;
            end
            next_st.falls     = '0;
            next_st.rises     = '0;
            next_st.holding   = 1'b1;
            next_st.shifter   = {{LEAD_ZEROS{1'b0}}, sampleIn, 1'b0};
            next_st.sdo       = 1'b0;
            next_st.sdoOe     = 1'b1;
        end else if (st.inFrame) begin
            if (csRise) begin
                next_st.inFrame = 1'b0;
                next_st.sdoOe   = 1'b0;
                next_st.holding = 1'b0;
                if (st.falls < FALLS_SHUT_MIN) begin
                    // Noise guard: a glitch on select leaves the mode unchanged
                    next_st.mode = st.frameMode;
                end else if (st.falls < FALLS_NORMAL_MIN) begin
                    next_st.mode  = MODE_SHUTDOWN;
                    next_st.abort = 1'b1;
                end else begin
                    next_st.mode  = MODE_NORMAL;
                    next_st.abort = 1'b1;
                end
            end else begin
                if (sclkFall) begin
                    next_st.falls   = st.falls + 5'h01;
                    next_st.shifter = {st.shifter[WORD_W-2:0], 1'b0};
                    next_st.sdo     = st.shifter[WORD_W-2];
                    if (next_st.falls == FALLS_FRAME) begin
                        next_st.sdoOe   = 1'b0;
                        next_st.inFrame = 1'b0;
                        next_st.done    = 1'b1;
                        // A wake frame converts while the analog side is still coming up
                        next_st.valid   = st.powered & ~st.wake;
                        next_st.powered = 1'b1;
                    end
                end
                if (sclkRise) begin
                    next_st.rises = st.rises + 5'h01;
                    if (next_st.rises == RISES_TRACK) begin
                        next_st.holding = 1'b0;
                    end
                end
            end
        end

        // Mode outputs are flops loaded from the next mode, so they move on
        // the same edge as the mode and never glitch while it is decoded
        next_st.shutOut   = (next_st.mode == MODE_SHUTDOWN);
        next_st.analogOut = (next_st.mode == MODE_NORMAL);
        next_st.trackOut  = ~next_st.holding;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st.sclkSync  <= 3'h7;
            st.csSync    <= 3'h7;
            st.sclkLvl   <= 1'b1;
            st.csLvl     <= 1'b1;
            st.mode      <= RST_MODE;
            st.frameMode <= RST_MODE;
            st.inFrame   <= 1'b0;
            st.wake      <= 1'b0;
            st.powered   <= 1'b0;
            st.falls     <= '0;
            st.rises     <= '0;
            st.shifter   <= '0;
            st.sdo       <= 1'b0;
            st.sdoOe     <= 1'b0;
            st.holding   <= 1'b0;
            st.done      <= 1'b0;
            st.valid     <= 1'b0;
            st.abort     <= 1'b0;
            // Output flops start in agreement with the reset mode
            st.shutOut   <= (RST_MODE == MODE_SHUTDOWN);
            st.analogOut <= (RST_MODE == MODE_NORMAL);
            st.trackOut  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.sdo     = st.sdo;
    assign link.sdoOe   = st.sdoOe;
    assign shutdownMode = st.shutOut;
    // Analog block is switched by its own flop, off for the whole of shutdown
    assign analogOn     = st.analogOut;
    assign tracking     = st.trackOut;
    assign poweredUp    = st.powered;
    assign convDone     = st.done;
    assign convValid    = st.valid;
    assign frameAbort   = st.abort;

endmodule

`default_nettype wire

//--- hdl/asf_host.sv
`timescale 1ns/100ps
`default_nettype none

module asf_host
    import asf_pkg::*;
#(
    parameter int unsigned SCLK_HALF   = SCLK_HALF_DEF,
    parameter int unsigned QUIET_CYC_P = QUIET_CYC
)(
    input  wire logic             mclk,
    input  wire logic             rst,
    asf_link_if.host              link,
    input  wire logic             startReq,
    input  wire logic [CNT_W-1:0] frameFalls,
    output logic                  busy,
    output logic [RES_W-1:0]      result,
    output logic                  resultStrobe,
    output logic                  resultFull,
    output logic                  resultDummy
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        asf_hst_state_t    state;
        logic [7:0]        div;
        logic [CNT_W-1:0]  falls;
        logic [CNT_W-1:0]  target;
        logic              csN;
        logic              sclk;
        logic [2:0]        sdoSync;
        logic              sdoLvl;
        logic [WORD_W-1:0] capture;
        logic [RES_W-1:0]  result;
        logic              strobe;
        logic              full;
        logic              dummy;
        logic              needDummy;
        logic              busy;
    } asf_hst_st_t;

    asf_hst_st_t st;
    asf_hst_st_t next_st;

    localparam logic [7:0] HALF_END  = 8'(SCLK_HALF - 1);
    localparam logic [7:0] QUIET_END = 8'(QUIET_CYC_P - 1);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st        = st;
        next_st.strobe = 1'b0;
        next_st.sdoSync = {st.sdoSync[1:0], link.sdoLine};
        if (st.sdoSync[1] == st.sdoSync[2]) begin
            next_st.sdoLvl = st.sdoSync[2];
        end
        next_st.div = st.div + 8'h01;

        case (st.state)
            HS_IDLE: begin
                next_st.div = '0;
                if (startReq) begin
                    next_st.target  = (frameFalls > FALLS_FRAME) ? FALLS_FRAME : frameFalls;
                    next_st.csN     = 1'b0;
                    next_st.falls   = '0;
                    next_st.capture = '0;
                    next_st.dummy   = st.needDummy;
                    next_st.busy    = 1'b1;
                    next_st.state   = HS_LEAD;
                end
            end
            HS_LEAD, HS_HIGH: begin
                if (st.div == HALF_END) begin
                    next_st.div = '0;
                    if (st.falls == st.target) begin
                        // Select always returns high, so an idle-low start never occurs
                        next_st.csN    = 1'b1;
                        next_st.strobe = 1'b1;
                        next_st.full   = (st.falls == FALLS_FRAME);
                        next_st.result = st.capture[RES_W:1];
                        if (st.falls == FALLS_FRAME) begin
                            next_st.needDummy = 1'b0;
                        end else if (st.falls >= FALLS_SHUT_MIN &&
                                     st.falls < FALLS_NORMAL_MIN) begin
                            next_st.needDummy = 1'b1;
                        end
                        next_st.state = HS_QUIET;
                    end else begin
                        // Round trip through both pin paths is eight clocks, one whole
                        // serial period at the default divider, so the bit is taken from
                        // the level settling on this edge; a shorter half period reads stale
                        next_st.sclk    = 1'b0;
                        next_st.capture = {st.capture[WORD_W-2:0], next_st.sdoLvl};
                        next_st.falls   = st.falls + 5'h01;
                        next_st.state   = HS_LOW;
                    end
                end
            end
            HS_LOW: begin
                if (st.div == HALF_END) begin
                    next_st.div   = '0;
                    next_st.sclk  = 1'b1;
                    next_st.state = HS_HIGH;
                end
            end
            HS_QUIET: begin
                if (st.div == QUIET_END) begin
                    next_st.div   = '0;
                    next_st.busy  = 1'b0;
                    next_st.state = HS_IDLE;
                end
            end
            default: begin
                next_st.state = HS_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st.state     <= HS_IDLE;
            st.div       <= '0;
            st.falls     <= '0;
            st.target    <= '0;
            st.csN       <= 1'b1;
            st.sclk      <= 1'b1;
            st.sdoSync   <= 3'h7;
            st.sdoLvl    <= 1'b1;
            st.capture   <= '0;
            st.result    <= '0;
            st.strobe    <= 1'b0;
            st.full      <= 1'b0;
            st.dummy     <= 1'b0;
            st.needDummy <= 1'b1;
            st.busy      <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign link.csN     = st.csN;
    assign link.sclk    = st.sclk;
    assign busy         = st.busy;
    assign result       = st.result;
    assign resultStrobe = st.strobe;
    assign resultFull   = st.full;
    assign resultDummy  = st.dummy;

endmodule

`default_nettype wire

//--- test/asf_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module asf_link_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sdoOe
);
    // ****************
    // Serial clock falls inside the current frame
    // ****************
    logic [4:0] falls;
    logic       csQ;
    logic       sclkQ;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            falls <= 5'h00;
            csQ   <= 1'b1;
            sclkQ <= 1'b1;
        end else begin
            csQ   <= csN;
            sclkQ <= sclk;
            if (csQ && !csN) begin
                falls <= 5'h00;
            end else if (!csN && sclkQ && !sclk && falls != 5'h1f) begin
                falls <= falls + 5'h01;
            end
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);

    // ****************
    // Link checks
    // ****************
    // Pin edges pass a synchroniser, so answers come 3 to 4 cycles late
    AST_DRIVE_ON_SELECT: assert property ($fell(csN) |-> ##[2:6] sdoOe)
        else $error("output not driven after select fall");
    AST_NO_EARLY_DRIVE: assert property ($rose(sdoOe) |-> !csN && !$past(csN, 2))
        else $error("output driven without select");
    AST_LEAD_ZEROS: assert property (sdoOe && !csN && falls <= 5'h02 |-> !sdo)
        else $error("leading bit not zero");
    AST_TRAIL_ZERO: assert property (sdoOe && !csN && falls == 5'h0f && $past(falls, 5) == 5'h0f |-> !sdo)
        else $error("bit after last result bit not zero");
    AST_SHIFT_ON_FALL: assert property (sdoOe && $past(sdoOe) && $changed(sdo) |-> $past(sclk, 5) && !$past(sclk, 2))
        else $error("output bit changed away from a clock fall");
    AST_RELEASE_AFTER_16: assert property (falls == 5'h10 && $past(falls) == 5'h0f |-> ##[0:6] !sdoOe)
        else $error("output still driven after sixteen falls");
    AST_RELEASE_ON_RISE: assert property ($rose(csN) |-> ##[1:6] !sdoOe)
        else $error("output still driven after select rise");
    AST_STAY_RELEASED: assert property (csN && $past(csN, 6) |-> !sdoOe)
        else $error("output driven between frames");
    AST_QUIET_GAP: assert property ($fell(csN) |-> $past(csN, 2) && $past(csN, 4))
        else $error("select lowered before quiet time");
    AST_FALL_LIMIT: assert property (falls <= 5'h10)
        else $error("more than sixteen falls in a frame");

    cover property ($rose(csN) && falls >= 5'h02 && falls <= 5'h09);
    cover property ($rose(csN) && falls >= 5'h0a && falls <= 5'h0f);
    cover property ($rose(csN) && falls == 5'h10);
    cover property ($rose(csN) && falls < 5'h02);
endmodule

`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench
    import asf_pkg::*;
;
    logic             mclk;
    logic             rst;
    logic             startReq;
    logic [CNT_W-1:0] frameFalls;
    logic [RES_W-1:0] sampleIn;
    logic             shutdownMode;
    logic             analogOn;
    logic             tracking;
    logic             poweredUp;
    logic             convDone;
    logic             convValid;
    logic             frameAbort;
    logic             busy;
    logic [RES_W-1:0] result;
    logic             resultStrobe;
    logic             resultFull;
    logic             resultDummy;
    int               errCount;
    int               samplesChecked;
    int               nDone;
    int               nValid;
    int               nAbort;
    int               nFalls;
    int               nStrobe;
    int               nHold;

    asf_link_if link ();

    asf_device i_asf_device (.mclk(mclk), .rst(rst), .link(link), .sampleIn(sampleIn),
        .shutdownMode(shutdownMode), .analogOn(analogOn), .tracking(tracking),
        .poweredUp(poweredUp), .convDone(convDone), .convValid(convValid),
        .frameAbort(frameAbort));

    asf_host i_asf_host (.mclk(mclk), .rst(rst), .link(link), .startReq(startReq),
        .frameFalls(frameFalls), .busy(busy), .result(result), .resultStrobe(resultStrobe),
        .resultFull(resultFull), .resultDummy(resultDummy));

    asf_link_asserts i_asf_link_asserts (.mclk(mclk), .rst(rst), .csN(link.csN),
        .sclk(link.sclk), .sdo(link.sdo), .sdoOe(link.sdoOe));

    // ****************
    // Clock and event counters
    // ****************
    always #12.5 mclk = ~mclk;

    always @(posedge mclk) begin
        if (convDone === 1'b1) nDone++;
        if (convValid === 1'b1) nValid++;
        if (frameAbort === 1'b1) nAbort++;
        if (resultStrobe === 1'b1) nStrobe++;
        if (tracking === 1'b0) nHold++;
    end

    always @(negedge link.sclk) begin
        if (link.csN === 1'b0) nFalls++;
    end

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        if (errCount == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One frame of f falls; checks pulse counts and the released wire
    task automatic frame(input logic [4:0] f, input int eDone, input int eValid, input int eAbort);
        int n;
        int d0;
        int v0;
        int a0;
        int s0;
        logic [4:0] fx;
        // A request for more than a word still gives sixteen clocks
        fx = (f > FALLS_FRAME) ? FALLS_FRAME : f;
        d0 = nDone;
        v0 = nValid;
        a0 = nAbort;
        s0 = nStrobe;
        nFalls = 0;
        nHold = 0;
        startReq = 1'b1;
        frameFalls = f;
        @(posedge mclk);
        #2;
        startReq = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge mclk);
            #2;
            n++;
        end
        if (n == 1000) begin
            chk("busy", 16'h0000, 16'h0001);
            summarize();
        end
        repeat (4) @(posedge mclk);
        #2;
        chk("falls", 16'(fx), 16'(nFalls));
        chk("done", 16'(eDone), 16'(nDone - d0));
        chk("valid", 16'(eValid), 16'(nValid - v0));
        chk("abort", 16'(eAbort), 16'(nAbort - a0));
        chk("strobe", 16'h0001, 16'(nStrobe - s0));
        chk("frame cycles", 16'h0001, 16'((n + 1) <= 20 * 2 * SCLK_HALF_DEF));
        chk("released", 16'h0000, 16'(link.sdoOe));
        chk("sclk idle", 16'h0001, 16'(link.sclk));
    endtask

    task automatic mode(input logic shut);
        chk("shutdown", 16'(shut), 16'(shutdownMode));
        chk("analog", 16'(!shut), 16'(analogOn));
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic s_wake_dummy();
        mode(1'b1);
        sampleIn = 12'ha5c;
        frame(5'h10, 1, 0, 0);
        mode(1'b0);
        chk("powered", 16'h0001, 16'(poweredUp));
        chk("dummy", 16'h0001, 16'(resultDummy));
        chk("tracking", 16'h0001, 16'(tracking));
        chk("hold cycles", 16'(2 * SCLK_HALF_DEF * RISES_TRACK), 16'(nHold));
    endtask

    task automatic s_words();
        logic [11:0] v [3] = '{12'h801, 12'h7fe, 12'hfff};
        foreach (v[i]) begin
            sampleIn = v[i];
            frame((i == 2) ? 5'h14 : 5'h10, 1, 1, 0);
            chk("result", 16'(v[i]), 16'(result));
            chk("full", 16'h0001, 16'(resultFull));
            chk("dummy", 16'h0000, 16'(resultDummy));
        end
    endtask

    task automatic s_truncate();
        logic [4:0] f [3] = '{5'h0a, 5'h0c, 5'h0f};
        foreach (f[i]) begin
            frame(f[i], 0, 0, 1);
            mode(1'b0);
            chk("full", 16'h0000, 16'(resultFull));
        end
        frame(5'h01, 0, 0, 0);
        mode(1'b0);
    endtask

    task automatic s_shutdown();
        logic [4:0] f [2] = '{5'h02, 5'h09};
        foreach (f[i]) begin
            frame(f[i], 0, 0, 1);
            mode(1'b1);
            frame(5'h10, 1, 0, 0);
            mode(1'b0);
        end
    endtask

    task automatic s_wake_paths();
        frame(5'h05, 0, 0, 1);
        repeat (200) @(posedge mclk);
        #2;
        mode(1'b1);
        frame(5'h01, 0, 0, 0);
        mode(1'b1);
        frame(5'h09, 0, 0, 1);
        mode(1'b1);
        frame(5'h0a, 0, 0, 1);
        mode(1'b0);
        chk("powered", 16'h0000, 16'(poweredUp));
        frame(5'h10, 1, 0, 0);
        chk("powered", 16'h0001, 16'(poweredUp));
        sampleIn = 12'h123;
        frame(5'h10, 1, 1, 0);
        chk("result", 16'h0123, 16'(result));
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        startReq = 1'b0;
        frameFalls = 5'h10;
        sampleIn = 12'h000;
        errCount = 0;
        samplesChecked = 0;
        nDone = 0;
        nValid = 0;
        nAbort = 0;
        nFalls = 0;
        nStrobe = 0;
        nHold = 0;
        repeat (8) @(posedge mclk);
        #2;
        rst = 1'b0;
        s_wake_dummy();
        s_words();
        s_truncate();
        s_shutdown();
        s_wake_paths();
        summarize();
    end
endmodule

`default_nettype wire
